// file: verilog/rti_pkg.sv
// Contract
// R1: nonexistent day becomes first of next month
// R2: three enable bits select event pin mode
// R3: alarm match drives event pin low, held
// R4: clearing alarm enable releases held alarm output
// R5: frequency mode outputs register-selected clock pattern
// R6: edge mode: first minute carry holds pin low
// R7: enable write during carry hold relowers pin
// R8: square mode: 30 s low, 30 s high
// R9: enable write while pin low relowers pin
// R10: minute modes ignore alarm/frequency register
// R11: supply sampled 15.6 ms once per second
// R12: low supply latches high, stops sampling
// R13: status read copies latch, restarts sampling
// R14: latch held until init or status read
// R15: first read after drop returns flag set
// R16: power-up outputs 1 Hz on event pin
// R17: host sends reset command before normal use
// R18: backed-up chip needs no reset from host
// R19: host checks test flag under noisy links
// R20: frequency bits 32768 Hz down to 1 Hz, ANDed
// R21: power-on loads status 82h, register 8000h
// R22: reset command clears status and register
// R23: status bit layout; supply flag read-only
package rti_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int XTAL_HZ = 32768;
   // fractional step gives a 65536 Hz tick, so counter bit 0 toggles at 32768 Hz
   localparam logic [26:0] PH_STEP = 27'(2 * XTAL_HZ);
   localparam logic [26:0] PH_WRAP = 27'(CLK_HZ);
   localparam int CARRY_HOLD_MS = 10;
   localparam int CARRY_HOLD_CYC = CLK_HZ / 1000 * CARRY_HOLD_MS;
   localparam int SAMPLE_WIN_NS = 15_600_000;
   localparam int SAMPLE_WIN_CYC = int'(64'(CLK_HZ) * 64'(SAMPLE_WIN_NS) / 64'd1_000_000_000);
   localparam logic [5:0] HALF_MINUTE_S = 6'd30;
   // register byte addresses
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_ALMFRQ = 8'h04;
   localparam logic [7:0] A_CMD = 8'h08;
   localparam logic [7:0] A_DATE = 8'h0C;
   localparam logic [7:0] A_STATE = 8'h10;
   // status fields
   localparam int B_SUPPLY = 7;
   localparam int B_HOUR24 = 6;
   localparam int B_ALARM = 5;
   localparam int B_MINUTE = 3;
   localparam int B_PERIODIC = 1;
   localparam logic [7:0] STATUS_RW_MASK = 8'h6A;
   localparam logic [7:0] STATUS_POR = 8'h82;
   localparam logic [15:0] ALMFRQ_POR = 16'h8000;
   localparam logic [7:0] STATUS_INIT = 8'h00;
   localparam logic [15:0] ALMFRQ_INIT = 16'h0000;
   localparam logic [23:0] DATE_INIT = 24'h00_0101;
   localparam int CMD_RESET = 0;
   typedef enum logic [2:0] {
      RTI_OFF,
      RTI_FREQ,
      RTI_EDGE,
      RTI_SQUARE,
      RTI_ALARM
   } rti_mode_t;
endpackage : rti_pkg

// file: verilog/rti_supply_if.sv
// signals shared between the event logic and the supply sampler
interface rti_supply_if;
   logic tick_1s;
   logic resume;
   logic init;
   logic supply_low;
   logic latch;
   logic detect_en;
   modport ctl (output tick_1s, output resume, output init, output supply_low, input latch, input detect_en);
   modport smp (input tick_1s, input resume, input init, input supply_low, output latch, output detect_en);
endinterface : rti_supply_if

// file: verilog/rti_supply_sampler.sv
module rti_supply_sampler #(
   parameter int WIN_CYC = rti_pkg::SAMPLE_WIN_CYC
) (
   input wire logic clock,
   input wire logic rst,
   rti_supply_if.smp sif
);
   // elaboration check on the window counter width
   if (WIN_CYC < 1 || WIN_CYC >= (1 << 24))
   begin : g_win_chk
      $error("window count out of range");
   end

   logic [23:0] win_q, win_d;
   logic open_q, open_d;
   logic seen_q, seen_d;
   logic latch_q, latch_d;
   logic stop_q, stop_d;

   // window opens on each second tick while sampling is not stopped, closes after the count
   always_comb
   begin
      win_d = win_q;
      open_d = open_q;
      seen_d = seen_q;
      latch_d = latch_q;
      stop_d = stop_q;
      // clears go first, so a drop found in the same cycle still sets the latch
      // a read restarts sampling but keeps the old result until a fresh sample
      if (sif.resume)
         stop_d = 1'b0; // R13 R14
      if (sif.init)
      begin
         latch_d = 1'b0; // R14
         stop_d = 1'b0;
         open_d = 1'b0;
      end
      if (open_q)
      begin
         seen_d = seen_q | sif.supply_low;
         if (win_q == 24'(WIN_CYC - 1))
         begin
            open_d = 1'b0;
            latch_d = seen_q | sif.supply_low; // R12
            stop_d = seen_q | sif.supply_low; // R12
         end
         else
            win_d = win_q + 24'd1;
      end
      else if (sif.tick_1s && !stop_q)
      begin
         open_d = 1'b1; // R11
         win_d = '0;
         seen_d = 1'b0;
      end
   end

   // power-up counts as a detected drop
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         win_q <= '0;
         open_q <= 1'b0;
         seen_q <= 1'b0;
         latch_q <= 1'b1;
         stop_q <= 1'b1;
      end
      else
      begin
         win_q <= win_d;
         open_q <= open_d;
         seen_q <= seen_d;
         latch_q <= latch_d;
         stop_q <= stop_d;
      end
   end

   assign sif.latch = latch_q;
   assign sif.detect_en = open_q; // R11
endmodule : rti_supply_sampler

// file: verilog/rti_event.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
module rti_event #(
   parameter int HOLD_CYC = rti_pkg::CARRY_HOLD_CYC,
   parameter int WIN_CYC = rti_pkg::SAMPLE_WIN_CYC,
   parameter int TICK_BITS = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] cur_hour,
   input wire logic [7:0] cur_minute,
   input wire logic minute_carry,
   input wire logic supply_threshold,
   output logic supply_detect_en,
   output logic event_n
);
   // elaboration checks on counts the logic cannot serve
   if (HOLD_CYC < 1 || HOLD_CYC >= (1 << 24))
   begin : g_hold_chk
      $error("carry hold count out of range");
   end
   if (TICK_BITS < 1 || TICK_BITS > 16)
   begin : g_tick_chk
      $error("second tick divider width out of range");
   end

   rti_supply_if sif ();

   // days in a month, bcd month in, leap year chosen by caller
   function automatic logic [7:0] month_days(input logic [7:0] mon, input logic leap);
      unique case (mon)
         8'h02: month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default: month_days = 8'h31;
      endcase
   endfunction : month_days

   // rolls a nonexistent day over to the first of the next month
   function automatic logic [23:0] fix_date(input logic [23:0] d);
      logic [6:0] yb;
      logic leap;
      logic [7:0] yr;
      logic [7:0] mo;
      yb = 7'(d[23:20] * 4'd10) + 7'(d[19:16]);
      leap = (yb[1:0] == 2'b00);
      yr = d[23:16];
      mo = d[15:8];
      fix_date = d;
      if (d[7:0] > month_days(mo, leap)) // R1
      begin
         if (mo == 8'h12)
         begin
            mo = 8'h01;
            yr = (yr == 8'h99) ? 8'h00 : ((yr[3:0] == 4'h9) ? {yr[7:4] + 4'h1, 4'h0} : yr + 8'h01);
         end
         else
            mo = (mo == 8'h09) ? 8'h10 : mo + 8'h01;
         fix_date = {yr, mo, 8'h01};
      end
   endfunction : fix_date

   // supply comparator pin crosses into the clock domain
   logic sup_s1_q, sup_s2_q;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sup_s1_q <= 1'b0;
         sup_s2_q <= 1'b0;
      end
      else
      begin
         sup_s1_q <= supply_threshold;
         sup_s2_q <= sup_s1_q;
      end
   end

   // crystal timebase: phase accumulator and 16-bit divider chain
   logic [26:0] ph_q, ph_d;
   logic [15:0] div_q, div_d;
   logic tick_1s;
   always_comb
   begin
      ph_d = ph_q + rti_pkg::PH_STEP;
      div_d = div_q;
      tick_1s = 1'b0;
      if (ph_d >= rti_pkg::PH_WRAP)
      begin
         ph_d = ph_d - rti_pkg::PH_WRAP;
         div_d = div_q + 16'd1;
         tick_1s = &div_q[TICK_BITS-1:0]; // fewer bits only to shorten benches
      end
   end
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ph_q <= '0;
         div_q <= '0;
      end
      else
      begin
         ph_q <= ph_d;
         div_q <= div_d;
      end
   end

   // register file and bus slave
   logic [7:0] status_q, status_d;
   logic [15:0] almfrq_q, almfrq_d;
   logic [23:0] date_q, date_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic stat_wr, stat_rd, init_cmd;
   logic acc;
   logic [31:0] wmask;
   assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   always_comb
   begin
      status_d = status_q;
      almfrq_d = almfrq_q;
      date_d = date_q;
      ack_d = acc;
      dat_d = dat_q;
      stat_wr = 1'b0;
      stat_rd = 1'b0;
      init_cmd = 1'b0;
      if (acc && wb_we_i)
      begin
         unique case (wb_adr_i)
            rti_pkg::A_STATUS:
               if (wb_sel_i[0])
               begin
                  // supply flag and unused bits ignore writes
                  status_d = (status_q & ~rti_pkg::STATUS_RW_MASK) | (wb_dat_i[7:0] & rti_pkg::STATUS_RW_MASK); // R23
                  stat_wr = 1'b1;
               end
            rti_pkg::A_ALMFRQ:
               almfrq_d = (almfrq_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            rti_pkg::A_DATE:
               date_d = fix_date((date_q & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0])); // R1
            rti_pkg::A_CMD:
               init_cmd = wb_sel_i[0] & wb_dat_i[rti_pkg::CMD_RESET];
            default: ;
         endcase
      end
      else if (acc)
      begin
         unique case (wb_adr_i)
            rti_pkg::A_STATUS:
            begin
               // the read itself fetches the latch, so the flag tracks the last sample
               dat_d = {24'h00_0000, sif.latch, status_q[6:0]}; // R13 R15
               status_d[rti_pkg::B_SUPPLY] = sif.latch;
               stat_rd = 1'b1;
            end
            rti_pkg::A_DATE: dat_d = {8'h00, date_q};
            rti_pkg::A_STATE: dat_d = {29'h0000_0000, sif.latch, sif.detect_en, event_n};
            default: dat_d = '0; // alarm/frequency register is write-only
         endcase
      end
      if (init_cmd)
      begin
         status_d = rti_pkg::STATUS_INIT; // R22
         almfrq_d = rti_pkg::ALMFRQ_INIT; // R22
         date_d = rti_pkg::DATE_INIT; // R22
      end
   end
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         status_q <= rti_pkg::STATUS_POR; // R21
         almfrq_q <= rti_pkg::ALMFRQ_POR; // R21 R16
         date_q <= rti_pkg::DATE_INIT;
         ack_q <= 1'b0;
         dat_q <= '0;
      end
      else
      begin
         status_q <= status_d;
         almfrq_q <= almfrq_d;
         date_q <= date_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // mode decode from the three enable bits
   rti_pkg::rti_mode_t mode;
   always_comb
   begin
      unique case ({status_q[rti_pkg::B_MINUTE], status_q[rti_pkg::B_PERIODIC]}) // R2
         2'b01: mode = rti_pkg::RTI_FREQ;
         2'b10: mode = rti_pkg::RTI_EDGE;
         2'b11: mode = rti_pkg::RTI_SQUARE;
         default: mode = status_q[rti_pkg::B_ALARM] ? rti_pkg::RTI_ALARM : rti_pkg::RTI_OFF;
      endcase
   end

   // event pin state: held alarm/edge low, carry hold timer, square phase
   logic hold_q, hold_d;
   logic sq_run_q, sq_run_d;
   logic sq_low_q, sq_low_d;
   logic [5:0] sec_q, sec_d;
   logic [23:0] carry_q, carry_d;
   logic [15:0] sel_clk;
   logic freq_lvl;
   logic ev_q, ev_d;
   assign sel_clk = div_q | ~almfrq_q;
   assign freq_lvl = &sel_clk; // R20
   always_comb
   begin
      hold_d = hold_q;
      sq_run_d = sq_run_q;
      sq_low_d = sq_low_q;
      sec_d = sec_q;
      carry_d = carry_q;
      // carry signal stays active for the hold time after each carry
      if (minute_carry)
         carry_d = 24'(HOLD_CYC);
      else if (carry_q != '0)
         carry_d = carry_q - 24'd1; // R7
      unique case (mode)
         rti_pkg::RTI_ALARM:
            if (cur_hour == almfrq_q[15:8] && cur_minute == almfrq_q[7:0])
               hold_d = 1'b1; // R3
         rti_pkg::RTI_EDGE:
         begin
            if (stat_wr)
               hold_d = (carry_q != '0); // R6 R7
            if (minute_carry)
               hold_d = 1'b1; // R6
         end
         rti_pkg::RTI_SQUARE:
         begin
            // the alarm/frequency register plays no part here
            if (minute_carry)
            begin
               sq_run_d = 1'b1; // R8 R10
               sq_low_d = 1'b1;
               sec_d = '0;
            end
            else if (sq_run_q && tick_1s)
            begin
               if (sec_q == rti_pkg::HALF_MINUTE_S - 6'd1)
               begin
                  sq_low_d = ~sq_low_q; // R8
                  sec_d = '0;
               end
               else
                  sec_d = sec_q + 6'd1;
            end
            if (stat_wr && sq_low_q)
            begin
               sq_low_d = 1'b1; // R9
               sec_d = '0;
            end
         end
         default: hold_d = 1'b0;
      endcase
      // clearing the alarm enable in alarm mode releases the held low
      if (stat_wr && mode == rti_pkg::RTI_ALARM && !status_d[rti_pkg::B_ALARM])
         hold_d = 1'b0; // R4
      if (mode != rti_pkg::RTI_SQUARE)
      begin
         sq_run_d = 1'b0;
         sq_low_d = 1'b0;
      end
      if (init_cmd)
         hold_d = 1'b0;
      unique case (mode)
         rti_pkg::RTI_FREQ: ev_d = freq_lvl; // R5 R16
         rti_pkg::RTI_ALARM, rti_pkg::RTI_EDGE: ev_d = ~hold_q; // R3 R6 R10
         rti_pkg::RTI_SQUARE: ev_d = ~sq_low_q; // R8
         default: ev_d = 1'b1;
      endcase
   end
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         hold_q <= 1'b0;
         sq_run_q <= 1'b0;
         sq_low_q <= 1'b0;
         sec_q <= '0;
         carry_q <= '0;
         ev_q <= 1'b1;
      end
      else
      begin
         hold_q <= hold_d;
         sq_run_q <= sq_run_d;
         sq_low_q <= sq_low_d;
         sec_q <= sec_d;
         carry_q <= carry_d;
         ev_q <= ev_d;
      end
   end
   assign event_n = ev_q;

   // supply sampler hookup
   assign sif.tick_1s = tick_1s;
   assign sif.resume = stat_rd; // R13
   assign sif.init = init_cmd; // R14
   assign sif.supply_low = sup_s2_q;
   assign supply_detect_en = sif.detect_en;

   rti_supply_sampler #(
      .WIN_CYC(WIN_CYC)
   ) u_sampler (
      .clock(clock),
      .rst(rst),
      .sif(sif)
   );
endmodule : rti_event

// file: testbench/rti_event_sva.sv
module rti_chk #(
   parameter int WIN_CYC = 20
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic supply_detect_en,
   input wire logic event_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   int win_q;
   // length of the open detect window, so a stuck window shows up
   always_ff @(posedge clock)
   begin
      if (rst || !supply_detect_en)
         win_q <= 0;
      else
         win_q <= win_q + 1;
   end
   // a pending request and the read that completes it
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rd_s;
      wb_ack_o && !$past(wb_we_i);
   endsequence
   chk_ack_follows: assert property (req_s |=> wb_ack_o)
      else $error("request without ack");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_status_rsvd: assert property (rd_s ##0 ($past(wb_adr_i) == 8'h00) |-> (wb_dat_o & 32'hFFFF_FF15) == '0)
      else $error("reserved status bits set");
   chk_almfrq_wo: assert property (rd_s ##0 ($past(wb_adr_i) == 8'h04) |-> wb_dat_o == '0)
      else $error("write-only register read back");
   chk_unmapped_zero: assert property (rd_s ##0 ($past(wb_adr_i) > 8'h10) |-> wb_dat_o == '0)
      else $error("unmapped read not zero");
   chk_reset_quiet: assert property ($fell(rst) |-> event_n && !wb_ack_o && !supply_detect_en)
      else $error("outputs busy after reset");
   chk_win_bound: assert property (win_q <= WIN_CYC)
      else $error("detect window too long");
   chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
      else $error("read data moved while idle");
endmodule : rti_chk

bind rti_event rti_chk #(.WIN_CYC(WIN_CYC)) chk_u (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .supply_detect_en(supply_detect_en), .event_n(event_n));

// file: testbench/rti_cal_model.sv
module rti_cal_model (
   input wire logic clock,
   output logic [7:0] cur_hour,
   output logic [7:0] cur_minute,
   output logic minute_carry,
   output logic supply_threshold
);
   timeunit 1ns;
   timeprecision 1ps;
   // calendar starts at midnight, supply healthy
   initial
   begin
      cur_hour = 8'h00;
      cur_minute = 8'h00;
      minute_carry = 1'b0;
      supply_threshold = 1'b0;
   end
   // time moves right after an edge, as the calendar counters would
   task automatic set_time(input logic [7:0] h, input logic [7:0] m);
      @(posedge clock);
      cur_hour <= h;
      cur_minute <= m;
   endtask : set_time
   // supply comparator level, changed just after an edge
   task automatic set_supply(input logic low);
      @(posedge clock);
      supply_threshold <= low;
   endtask : set_supply
   // one-cycle carry pulse
   task automatic carry();
      @(posedge clock);
      minute_carry <= 1'b1;
      @(posedge clock);
      minute_carry <= 1'b0;
   endtask : carry
endmodule : rti_cal_model

// file: testbench/rti_event_tb_top.sv
module rti_event_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, cyc, stb, we, ack, ev, carry, thr, den;
   logic [7:0] adr, hr, mn;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd;
   logic [23:0] dw [3] = '{24'h01_0229, 24'h04_0229, 24'h00_0431};
   logic [23:0] de [3] = '{24'h01_0301, 24'h04_0229, 24'h00_0501};
   int failures, n_checks, cyc_cnt, tog;
   // 40 MHz
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // short hold and window counts and a fast second tick keep the run small
   rti_event #(.HOLD_CYC(40), .WIN_CYC(20), .TICK_BITS(2)) dut_u (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .cur_hour(hr), .cur_minute(mn), .minute_carry(carry), .supply_threshold(thr),
      .supply_detect_en(den), .event_n(ev));
   rti_cal_model cal_u (.clock(clock), .cur_hour(hr), .cur_minute(mn), .minute_carry(carry),
      .supply_threshold(thr));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // one classic cycle; waits on ack, the timeout guards a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do @(posedge clock); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // pin lags two cycles behind its cause
   task automatic ev_is(input logic e, input string what);
      repeat (3) @(posedge clock);
      chk(32'(ev), 32'(e), what);
   endtask : ev_is
   task automatic watch(input int n);
      logic last;
      tog = 0;
      // let a pin change caused by the last write settle first
      repeat (2) @(posedge clock);
      last = ev;
      repeat (n)
      begin
         @(posedge clock);
         if (ev !== last)
            tog++;
         last = ev;
      end
   endtask : watch
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // hang guard, well above the expected fifteen thousand or so cycles
   always @(posedge clock)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000)
      begin
         failures++;
         close_out();
      end
   end
   initial
   begin
      rst = 1'b1;
      {cyc, stb, we, adr, sel, wdat} = '0;
      {failures, n_checks, cyc_cnt} = '0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      wb(1'b0, 8'h00, '0);
      chk(rd, 32'h0000_0082, "status after power-on");
      wb(1'b0, 8'h10, '0);
      chk(32'(rd[2:1]), 32'h0000_0002, "drop latch held");
      wb(1'b0, 8'h04, '0);
      chk(rd, '0, "write-only read");
      wb(1'b0, 8'h14, '0);
      chk(rd, '0, "unmapped read");
      $display("test power-on done");
      wb(1'b1, 8'h08, 32'h0000_0001);
      wb(1'b0, 8'h00, '0);
      chk(rd, '0, "status after reset command");
      wb(1'b1, 8'h00, 32'h0000_00FF);
      wb(1'b0, 8'h00, '0);
      chk(rd, 32'h0000_006A, "status writable bits");
      for (int i = 0; i < 3; i++)
      begin
         wb(1'b1, 8'h0C, 32'(dw[i]));
         wb(1'b0, 8'h0C, '0);
         chk(rd, 32'(de[i]), "date correction");
      end
      $display("test registers done");
      wb(1'b1, 8'h00, '0);
      ev_is(1'b1, "output disabled");
      wb(1'b1, 8'h04, 32'h0000_1230);
      wb(1'b1, 8'h00, 32'h0000_0020);
      cal_u.set_time(8'h12, 8'h29);
      ev_is(1'b1, "alarm before match");
      cal_u.set_time(8'h12, 8'h30);
      ev_is(1'b0, "alarm match");
      cal_u.set_time(8'h12, 8'h31);
      ev_is(1'b0, "alarm held");
      wb(1'b1, 8'h00, '0);
      ev_is(1'b1, "alarm released");
      $display("test alarm done");
      wb(1'b1, 8'h04, 32'h0000_0001);
      wb(1'b1, 8'h00, 32'h0000_0022);
      watch(3000);
      chk(32'(tog >= 4), 32'h0000_0001, "fastest tap toggles");
      wb(1'b1, 8'h04, '0);
      watch(3000);
      chk(32'(tog), '0, "no tap stays high");
      $display("test frequency done");
      wb(1'b1, 8'h00, 32'h0000_0008);
      ev_is(1'b1, "edge waits for carry");
      cal_u.carry();
      ev_is(1'b0, "edge low on carry");
      wb(1'b1, 8'h00, 32'h0000_0008);
      ev_is(1'b0, "write during carry hold");
      repeat (50) @(posedge clock);
      wb(1'b1, 8'h00, 32'h0000_0008);
      ev_is(1'b1, "edge released");
      $display("test edge done");
      wb(1'b1, 8'h00, 32'h0000_000A);
      cal_u.carry();
      ev_is(1'b0, "square low phase");
      wb(1'b1, 8'h04, 32'h0000_FFFF);
      ev_is(1'b0, "square ignores register");
      wb(1'b1, 8'h00, 32'h0000_000A);
      ev_is(1'b0, "square relowered");
      $display("test square done");
      // a tick comes every four divider steps, so 3000 cycles hold one window
      cal_u.set_supply(1'b1);
      repeat (3000) @(posedge clock);
      wb(1'b0, 8'h10, '0);
      chk(32'(rd[2]), 32'h0000_0001, "low supply latched");
      cal_u.set_supply(1'b0);
      repeat (3000) @(posedge clock);
      wb(1'b0, 8'h10, '0);
      chk(32'(rd[2]), 32'h0000_0001, "latch held while stopped");
      wb(1'b0, 8'h00, '0);
      chk(32'(rd[7]), 32'h0000_0001, "first read after drop");
      repeat (3000) @(posedge clock);
      wb(1'b0, 8'h00, '0);
      chk(32'(rd[7]), '0, "flag clears after fresh sample");
      $display("test supply done");
      close_out();
   end
endmodule : rti_event_tb_top
